// ---- logic/lmad_regs.vh ----
// Address map, strap codes and register layout for the local memory address decoder
`ifndef LMAD_REGS_VH
`define LMAD_REGS_VH
// Program bank bases and socket-pair spans, indexed by the two size straps
`define LMAD_PROM_BASE_8K 20'hf8000
`define LMAD_PROM_BASE_16K 20'hf0000
`define LMAD_PROM_BASE_32K 20'he0000
`define LMAD_PROM_BASE_64K 20'hc0000
`define LMAD_PROM_SPAN_8K 20'h04000
`define LMAD_PROM_SPAN_16K 20'h08000
`define LMAD_PROM_SPAN_32K 20'h10000
`define LMAD_PROM_SPAN_64K 20'h20000
// Companion processor memory size (16K bytes)
`define LMAD_COMP_SIZE 20'h04000
// Data bank socket-pair spans when bottom-justified
`define LMAD_RAM_SPAN_2K 20'h01000
`define LMAD_RAM_SPAN_8K 20'h04000
`define LMAD_RAM_SPAN_32K 20'h10000
`define LMAD_RAM_LOW_BASE 20'h00000
// Data bank strap codes {202-203, 200-201, 198-199}
`define LMAD_RAM_LOW_2K 3'h0
`define LMAD_RAM_LOW_8K 3'h1
`define LMAD_RAM_LOW_32K 3'h2
`define LMAD_RAM_LOW_NONE 3'h3
`define LMAD_RAM_ALL_OFF 3'h7
`define LMAD_RAM_TOP_BIT 2
// Wait-state strap fields
`define LMAD_WS_RAM_LSB 0
`define LMAD_WS_PROM_LSB 2
`define LMAD_WS_MAX 2'h2
// Register offsets (byte addresses)
`define LMAD_REG_CTRL 4'h0
`define LMAD_REG_STATUS 4'h4
// Control register fields and reset value
`define LMAD_CTRL_DEC_EN 0
`define LMAD_CTRL_RESET 32'h0000_0001
// Status register field positions
`define LMAD_ST_STRAPS_LSB 0
`define LMAD_ST_HIT_LSB 16
// AXI response codes
`define LMAD_RESP_OKAY 2'h0
`define LMAD_RESP_SLVERR 2'h2
`endif

// ---- logic/lmad_top.v ----
// Local memory address decoder with strap-driven map, wait states and AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - Program bank always ends at the top of the 1 MB space.
// - Data bank sits at zero or just below the program bank, per strap.
// - Two size straps pick program devices 8K, 16K, 32K or 64K.
// - Companion 16K memory decodes directly below the program bank unless the data bank is moved up.
// - Companion memory answers only while its enable strap is installed.
// - Bottom data bank supports 2K, 8K and 32K devices only.
// - Zero, one or two wait states per bank, chosen by straps.
// - Socket pairs in a bank have equal, adjacent ranges.
// - Top data bank matches program size; companion then sits below it.
// - With data bank off or moved up, expansion range starts at zero.
`include "lmad_regs.vh"
module lmad_top (
  input wire SYS_CLK,
  input wire RST_N,
  input wire [19:0] CPU_ADDR,
  input wire CPU_MEM_CYCLE,
  input wire CPU_BHE_N,
  input wire PROM_SIZE_STRAP_HI,
  input wire PROM_SIZE_STRAP_LO,
  input wire [2:0] RAM_SIZE_PLACE_STRAPS,
  input wire COMPANION_MEM_ENABLE_STRAP,
  input wire [3:0] WAIT_STATE_STRAPS,
  input wire EXP_BUS_ENABLE,
  output reg [1:0] PROM_PAIR_CE_N,
  output reg [1:0] RAM_PAIR_CE_N,
  output reg COMPANION_CE_N,
  output reg SOCKET_EVEN_EN_N,
  output reg SOCKET_ODD_EN_N,
  output reg EXP_BUS_SEL,
  output wire LOCAL_READY,
  input wire [3:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [3:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  reg [19:0] prom_base;
  reg [19:0] prom_span;
  reg [19:0] ram_base;
  reg [19:0] ram_span;
  reg [19:0] comp_base;
  reg ram_on;
  reg ram_top;
  reg [19:0] prom_mask;
  reg [19:0] ram_mask;
  wire [19:0] comp_mask;
  wire prom_hit;
  wire ram_hit;
  wire comp_hit;
  wire local_hit;
  wire [1:0] ws_ram;
  wire [1:0] ws_prom;
  reg [1:0] next_wait;
  reg [1:0] wait_cnt;
  reg cycle_seen;
  reg [31:0] ctrl;
  reg [2:0] last_hit;
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire dec_en;
  wire [1:0] sizes;
  integer i;

  assign dec_en = ctrl[`LMAD_CTRL_DEC_EN];
  assign sizes = {PROM_SIZE_STRAP_HI, PROM_SIZE_STRAP_LO};

  // Program bank placement and pair span from the size straps
  always @* begin
    case (sizes)
      2'b00: begin
        prom_base = `LMAD_PROM_BASE_8K;
        prom_span = `LMAD_PROM_SPAN_8K;
      end
      2'b01: begin
        prom_base = `LMAD_PROM_BASE_16K;
        prom_span = `LMAD_PROM_SPAN_16K;
      end
      2'b10: begin
        prom_base = `LMAD_PROM_BASE_32K;
        prom_span = `LMAD_PROM_SPAN_32K;
      end
      default: begin
        prom_base = `LMAD_PROM_BASE_64K;
        prom_span = `LMAD_PROM_SPAN_64K;
      end
    endcase
    // Bank is two pairs, so its top always lands on FFFFF
    prom_mask = ~((prom_span << 1) - 20'h00001);
  end

  // Data bank placement, size and companion placement
  always @* begin
    ram_top = RAM_SIZE_PLACE_STRAPS[`LMAD_RAM_TOP_BIT];
    ram_on = 1'b1;
    ram_base = `LMAD_RAM_LOW_BASE;
    ram_span = `LMAD_RAM_SPAN_2K;
    comp_base = prom_base - `LMAD_COMP_SIZE;
    if (RAM_SIZE_PLACE_STRAPS == `LMAD_RAM_ALL_OFF) begin
      ram_on = 1'b0;
    end else if (ram_top) begin
      // Same pair span as the program bank, stacked just below it
      ram_span = prom_span;
      ram_base = prom_base - (prom_span << 1);
      comp_base = ram_base - `LMAD_COMP_SIZE;
    end else if (RAM_SIZE_PLACE_STRAPS == `LMAD_RAM_LOW_2K) begin
      ram_span = `LMAD_RAM_SPAN_2K;
    end else if (RAM_SIZE_PLACE_STRAPS == `LMAD_RAM_LOW_8K) begin
      ram_span = `LMAD_RAM_SPAN_8K;
    end else if (RAM_SIZE_PLACE_STRAPS == `LMAD_RAM_LOW_32K) begin
      ram_span = `LMAD_RAM_SPAN_32K;
    end else begin
      ram_on = 1'b0;
    end
    ram_mask = ~((ram_span << 1) - 20'h00001);
  end

  assign comp_mask = ~(`LMAD_COMP_SIZE - 20'h00001);
  assign prom_hit = ((CPU_ADDR ^ prom_base) & prom_mask) == 20'h00000;
  assign ram_hit = ram_on & (((CPU_ADDR ^ ram_base) & ram_mask) == 20'h00000) & ~prom_hit;
  // Companion off with its strap out, and off when the whole data row is disabled
  assign comp_hit = COMPANION_MEM_ENABLE_STRAP & (RAM_SIZE_PLACE_STRAPS != `LMAD_RAM_ALL_OFF) &
    (((CPU_ADDR ^ comp_base) & comp_mask) == 20'h00000) & ~prom_hit & ~ram_hit;
  assign local_hit = prom_hit | ram_hit | comp_hit;

  // Registered chip enables; one pair at most, lanes from A0 and BHE
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PROM_PAIR_CE_N <= 2'h3;
      RAM_PAIR_CE_N <= 2'h3;
      COMPANION_CE_N <= 1'b1;
      SOCKET_EVEN_EN_N <= 1'b1;
      SOCKET_ODD_EN_N <= 1'b1;
      EXP_BUS_SEL <= 1'b0;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        // Pair index is the span bit of the address, giving adjacent equal ranges
        PROM_PAIR_CE_N[i] <= ~(CPU_MEM_CYCLE & dec_en & prom_hit &
          ((|(CPU_ADDR & prom_span)) == i[0]));
        RAM_PAIR_CE_N[i] <= ~(CPU_MEM_CYCLE & dec_en & ram_hit &
          ((|(CPU_ADDR & ram_span)) == i[0]));
      end
      COMPANION_CE_N <= ~(CPU_MEM_CYCLE & dec_en & comp_hit);
      SOCKET_EVEN_EN_N <= ~(CPU_MEM_CYCLE & dec_en & (prom_hit | ram_hit) & ~CPU_ADDR[0]);
      SOCKET_ODD_EN_N <= ~(CPU_MEM_CYCLE & dec_en & (prom_hit | ram_hit) & ~CPU_BHE_N);
      // Expansion range from zero when the data bank is not low
      EXP_BUS_SEL <= CPU_MEM_CYCLE & EXP_BUS_ENABLE & ~local_hit &
        (~ram_on | ram_top | ~ram_hit);
    end
  end

  // Wait-state count for the bank being hit, strap value 3 clipped to 2
  assign ws_ram = (WAIT_STATE_STRAPS[`LMAD_WS_RAM_LSB +: 2] > `LMAD_WS_MAX) ? `LMAD_WS_MAX :
    WAIT_STATE_STRAPS[`LMAD_WS_RAM_LSB +: 2];
  assign ws_prom = (WAIT_STATE_STRAPS[`LMAD_WS_PROM_LSB +: 2] > `LMAD_WS_MAX) ? `LMAD_WS_MAX :
    WAIT_STATE_STRAPS[`LMAD_WS_PROM_LSB +: 2];
  always @* begin
    next_wait = 2'h0;
    if (ram_hit) begin
      next_wait = ws_ram;
    end else if (prom_hit) begin
      next_wait = ws_prom;
    end
  end

  // Wait counter: loaded when the cycle opens, counts down to ready
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cycle_seen <= 1'b0;
      wait_cnt <= 2'h0;
      last_hit <= 3'h0;
    end else begin
      cycle_seen <= CPU_MEM_CYCLE;
      if (CPU_MEM_CYCLE && !cycle_seen) begin
        wait_cnt <= next_wait;
        last_hit <= {comp_hit, ram_hit, prom_hit};
      end else if (wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
  assign LOCAL_READY = CPU_MEM_CYCLE & cycle_seen & local_hit & dec_en & (wait_cnt == 2'h0);

  // AXI4-Lite write path: address and data taken in either order
  assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
  assign S_AXI_WREADY = ~w_held & ~S_AXI_BVALID;
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      ctrl <= `LMAD_CTRL_RESET;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `LMAD_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        if (aw_addr == `LMAD_REG_CTRL) begin
          S_AXI_BRESP <= `LMAD_RESP_OKAY;
          if (w_strb[0]) begin
            ctrl[7:0] <= w_data[7:0];
          end
          if (w_strb[1]) begin
            ctrl[15:8] <= w_data[15:8];
          end
          if (w_strb[2]) begin
            ctrl[23:16] <= w_data[23:16];
          end
          if (w_strb[3]) begin
            ctrl[31:24] <= w_data[31:24];
          end
        end else if (aw_addr == `LMAD_REG_STATUS) begin
          S_AXI_BRESP <= `LMAD_RESP_OKAY;
        end else begin
          S_AXI_BRESP <= `LMAD_RESP_SLVERR;
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path: one read at a time, answered the cycle after ARVALID
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= `LMAD_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      if (S_AXI_ARADDR == `LMAD_REG_CTRL) begin
        S_AXI_RDATA <= ctrl;
        S_AXI_RRESP <= `LMAD_RESP_OKAY;
      end else if (S_AXI_ARADDR == `LMAD_REG_STATUS) begin
        S_AXI_RDATA <= {13'h0, last_hit, 5'h0, EXP_BUS_ENABLE, WAIT_STATE_STRAPS,
          COMPANION_MEM_ENABLE_STRAP, RAM_SIZE_PLACE_STRAPS, sizes};
        S_AXI_RRESP <= `LMAD_RESP_OKAY;
      end else begin
        S_AXI_RDATA <= 32'h0;
        S_AXI_RRESP <= `LMAD_RESP_SLVERR;
      end
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule // lmad_top

// ---- sim/lmad_checker.sv ----
// Port-level assertions for the decoder
`timescale 1ns/1ps
module lmad_checker (
  input wire SYS_CLK,
  input wire RST_N,
  input wire [19:0] CPU_ADDR,
  input wire CPU_MEM_CYCLE,
  input wire PROM_SIZE_STRAP_HI,
  input wire PROM_SIZE_STRAP_LO,
  input wire [2:0] RAM_SIZE_PLACE_STRAPS,
  input wire COMPANION_MEM_ENABLE_STRAP,
  input wire [3:0] WAIT_STATE_STRAPS,
  input wire EXP_BUS_ENABLE,
  input wire [1:0] PROM_PAIR_CE_N,
  input wire [1:0] RAM_PAIR_CE_N,
  input wire COMPANION_CE_N,
  input wire EXP_BUS_SEL,
  input wire LOCAL_READY,
  input wire [3:0] S_AXI_AWADDR,
  input wire [31:0] S_AXI_WDATA,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY
);
  reg en;
  wire cyc = CPU_MEM_CYCLE && en;
  wire top = CPU_ADDR[19:13] == 7'h7f;
  default clocking dc @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Mirror of the decode enable bit
  always @(posedge SYS_CLK) begin
    if (!RST_N) en <= 1'h1;
    else if (S_AXI_WVALID && S_AXI_WREADY && S_AXI_AWADDR == 4'h0) en <= S_AXI_WDATA[0];
  end
  a_prom_top:
    assert property (cyc && top |=> !PROM_PAIR_CE_N[1]) else $error("prom top");
  a_comp_below:
    assert property (cyc && COMPANION_MEM_ENABLE_STRAP && !PROM_SIZE_STRAP_HI && !PROM_SIZE_STRAP_LO
      && RAM_SIZE_PLACE_STRAPS == 3'h0 && CPU_ADDR[19:14] == 6'h3d |=> !COMPANION_CE_N) else $error("comp");
  a_ram_pair:
    assert property (cyc && RAM_SIZE_PLACE_STRAPS == 3'h0 && CPU_ADDR[19:12] == 8'h01
      |=> RAM_PAIR_CE_N == 2'h1) else $error("ram pair");
  a_ready_now:
    assert property ($rose(CPU_MEM_CYCLE) && en && top && WAIT_STATE_STRAPS[3:2] == 2'h0 |=> LOCAL_READY)
      else $error("ready 0");
  a_ready_two:
    assert property ($rose(CPU_MEM_CYCLE) && en && top && WAIT_STATE_STRAPS[3:2] == 2'h2
      |=> !LOCAL_READY ##1 !LOCAL_READY ##1 LOCAL_READY) else $error("ready 2");
  a_exp_low:
    assert property (cyc && EXP_BUS_ENABLE && RAM_SIZE_PLACE_STRAPS[2] && CPU_ADDR[19:16] == 4'h0 |=> EXP_BUS_SEL)
      else $error("exp low");
  a_one_pair:
    assert property ($countones({~PROM_PAIR_CE_N, ~RAM_PAIR_CE_N, ~COMPANION_CE_N}) <= 1) else $error("two");
  a_decode_off:
    assert property (!en && !$past(en, 3) |-> &{PROM_PAIR_CE_N, RAM_PAIR_CE_N, COMPANION_CE_N}) else $error("off");
endmodule // lmad_checker
bind lmad_top lmad_checker u_chk (.*);

// ---- sim/lmad_cpu_model.sv ----
// CPU local bus model that runs one memory cycle per request
`timescale 1ns/1ps
module lmad_cpu_model (
  input wire clk,
  input wire go,
  input wire [19:0] addr,
  input wire bhe_n,
  input wire ready,
  output reg [19:0] cpu_addr = 20'h0,
  output reg mem_cycle = 1'h0,
  output reg bhe_out = 1'h1,
  output reg busy = 1'h0,
  output reg [3:0] waited = 4'h0
);
  // Hold the cycle until ready or give up, then scramble the released lines
  always @(posedge clk) begin
    if (go && !busy) begin
      cpu_addr <= addr;
      bhe_out <= bhe_n;
      mem_cycle <= 1'h1;
      busy <= 1'h1;
      waited <= 4'h0;
    end else if (busy) begin
      waited <= waited + 4'h1;
      if (ready || waited == 4'h7) begin
        mem_cycle <= 1'h0;
        cpu_addr <= ~cpu_addr;
        bhe_out <= ~bhe_out;
        busy <= 1'h0;
      end
    end
  end
endmodule // lmad_cpu_model

// ---- sim/lmad_top_bench.sv ----
// Bench: strap sweeps, CPU cycles and register accesses
`timescale 1ns/1ps
`include "lmad_regs.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module lmad_top_bench;
  reg SYS_CLK = 1'h0, RST_N = 1'h0, PROM_SIZE_STRAP_HI = 1'h0, PROM_SIZE_STRAP_LO = 1'h0;
  reg COMPANION_MEM_ENABLE_STRAP = 1'h1, EXP_BUS_ENABLE = 1'h1, S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0;
  reg S_AXI_BREADY = 1'h0, S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0, go = 1'h0, gb = 1'h1;
  reg [2:0] RAM_SIZE_PLACE_STRAPS = 3'h0;
  reg [3:0] WAIT_STATE_STRAPS = 4'h0, S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hf;
  reg [31:0] S_AXI_WDATA = 32'h0, rd;
  reg [19:0] ga = 20'h0;
  reg [1:0] resp;
  wire [19:0] CPU_ADDR;
  wire CPU_MEM_CYCLE, CPU_BHE_N, COMPANION_CE_N, SOCKET_EVEN_EN_N, SOCKET_ODD_EN_N, EXP_BUS_SEL, LOCAL_READY;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, busy;
  wire [1:0] PROM_PAIR_CE_N, RAM_PAIR_CE_N, S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  wire [3:0] waited;
  integer seed = 32'hbe027762, mismatches = 0, comparisons = 0, dec_on = 1, i, e, w, n, ps, pb, rs, rb, cb;
  lmad_top u_dut (.*);
  lmad_cpu_model u_cpu (.clk(SYS_CLK), .go(go), .addr(ga), .bhe_n(gb), .ready(LOCAL_READY),
    .cpu_addr(CPU_ADDR), .mem_cycle(CPU_MEM_CYCLE), .bhe_out(CPU_BHE_N), .busy(busy), .waited(waited));
  initial forever #5 SYS_CLK = ~SYS_CLK;
  // Reference map: program pairs at the top, data bank low or below, companion below those
  function integer model(input integer a);
    begin
      ps = 32'h4000 << {PROM_SIZE_STRAP_HI, PROM_SIZE_STRAP_LO};
      pb = 32'h100000 - 2 * ps;
      rs = RAM_SIZE_PLACE_STRAPS < 3 ? 32'h1000 << (2 * RAM_SIZE_PLACE_STRAPS) : 0;
      rb = 0;
      if (RAM_SIZE_PLACE_STRAPS[2] && RAM_SIZE_PLACE_STRAPS != 3'h7) begin rs = ps; rb = pb - 2 * ps; end
      cb = (rb ? rb : pb) - 32'h4000;
      model = EXP_BUS_ENABLE ? 32 : 0;
      if (!dec_on) model = 0;
      else if (a >= pb) model = 1 << ((a - pb) / ps);
      else if (rs && a >= rb && a < rb + 2 * rs) model = 4 << ((a - rb) / rs);
      else if (COMPANION_MEM_ENABLE_STRAP && RAM_SIZE_PLACE_STRAPS != 3'h7 && a >= cb && a < cb + 32'h4000) model = 16;
    end
  endfunction
  // One register bus transfer; write when wr is set
  task axi(input integer wr, input [3:0] ad, input [31:0] d);
    begin
      n = 0;
      if (wr) begin S_AXI_AWADDR <= ad; S_AXI_WDATA <= d; S_AXI_AWVALID <= 1'h1; S_AXI_WVALID <= 1'h1; end
      else begin S_AXI_ARADDR <= ad; S_AXI_ARVALID <= 1'h1; end
      S_AXI_BREADY <= wr != 0;
      S_AXI_RREADY <= wr == 0;
      do begin
        @(posedge SYS_CLK);
        n++;
        if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
        if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
        if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
        resp = wr ? S_AXI_BRESP : S_AXI_RRESP;
        rd = S_AXI_RDATA;
      end while (!(wr ? S_AXI_BVALID : S_AXI_RVALID) && n < 40);
      // A bus answer that never comes is a failure
      if (n >= 40) mismatches++;
      S_AXI_BREADY <= 1'h0;
      S_AXI_RREADY <= 1'h0;
    end
  endtask
  // One CPU memory cycle through the bus model
  task acc(input integer a);
    begin
      e = model(a);
      ga <= a[19:0];
      gb <= $random(seed);
      go <= 1'h1;
      @(posedge SYS_CLK);
      go <= 1'h0;
      @(posedge SYS_CLK);
      #1;
      `CHK("enables", e, {EXP_BUS_SEL, ~COMPANION_CE_N, ~RAM_PAIR_CE_N, ~PROM_PAIR_CE_N})
      if (e > 0 && e < 16) `CHK("lanes", {gb, a[0]}, {SOCKET_ODD_EN_N, SOCKET_EVEN_EN_N})
      // Companion memory runs with no inserted waits
      w = e < 4 ? WAIT_STATE_STRAPS[3:2] : e < 16 ? WAIT_STATE_STRAPS[1:0] : 0;
      n = 0;
      while (busy && n < 20) begin @(posedge SYS_CLK); n++; end
      if (n >= 20) mismatches++;
      `CHK("waits", (e == 0 || e == 32) ? 8 : (w > 2 ? 2 : w) + 2, waited)
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #600000;
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge SYS_CLK);
    RST_N <= 1'h1;
    @(posedge SYS_CLK);
    axi(0, `LMAD_REG_CTRL, 0);
    `CHK("ctrl", `LMAD_CTRL_RESET, rd)
    axi(0, 4'h8, 0);
    `CHK("unmapped", `LMAD_RESP_SLVERR, resp)
    axi(1, `LMAD_REG_CTRL, 0);
    `CHK("bresp", `LMAD_RESP_OKAY, resp)
    dec_on = 0;
    EXP_BUS_ENABLE <= 1'h0;
    acc(32'hfffff);
    axi(1, `LMAD_REG_CTRL, 1);
    dec_on = 1;
    EXP_BUS_ENABLE <= 1'h1;
    $display("test registers done");
    for (i = 0; i < 40; i++) begin
      if (i > 0) {PROM_SIZE_STRAP_HI, PROM_SIZE_STRAP_LO, RAM_SIZE_PLACE_STRAPS, COMPANION_MEM_ENABLE_STRAP,
        WAIT_STATE_STRAPS, EXP_BUS_ENABLE} <= $random(seed);
      @(posedge SYS_CLK);
      axi(0, `LMAD_REG_STATUS, 0);
      `CHK("status", {EXP_BUS_ENABLE, WAIT_STATE_STRAPS, COMPANION_MEM_ENABLE_STRAP, RAM_SIZE_PLACE_STRAPS,
        PROM_SIZE_STRAP_HI, PROM_SIZE_STRAP_LO}, rd[10:0])
      e = model(0);
      acc($random(seed) & 32'hfffff);
      acc(pb);
      acc(pb + ps);
      acc(pb - 1);
      acc(cb);
      acc(rb + rs);
      acc((rb + 2 * rs - 1) & 32'hfffff);
      acc(0);
    end
    $display("test decode done");
    complete_run;
  end
endmodule // lmad_top_bench
